// ### sbcd_pkg.sv
// Contract
// (RQ1) host disposes of a null message by clearing or reading it
// (RQ2) receive store pointer never advances onto the fetch pointer slot
// (RQ3) data after last writable slot overwrites it and sets rx_overrun_flag
// (RQ4) reading the receive buffer clears rx_overrun_flag
// (RQ5) host checks rx_overrun_flag before servicing the receive buffer
// (RQ6) first byte 0x01-0x1B or 0x95-0x9B accesses a register
// (RQ7) command 0x20 resets transmit buffer and clears both slot indexes
// (RQ8) 0x91 reads from fetch pointer, advancing per byte, not past message end
// (RQ9) 0x93 restarts at oldest unread message, not advancing into next one
// (RQ10) 0xB0-0xBC advance fill_slot_index, then write the new load queue; the code acts on even codes only, odd ones are ignored
// (RQ11) the advance happens even without data bytes
// (RQ12) even code selects start location, writes continue through location 6
// (RQ13) data bytes beyond location 6 are ignored
// (RQ14) 0xC0-0xCA write current load queue without changing fill_slot_index; the code acts on even codes only, odd ones are ignored
// (RQ15) fill and send slot indexes are two-bit counters wrapping 3 to 0
// (RQ16) advance on full transmit buffer is suppressed and sets tx_overrun_flag
// (RQ17) receive buffer empty when fetch is one below store; reads return zero
// (RQ18) undecoded command bytes make the whole transaction inert
package sbcd_pkg;
    localparam logic [7:0] CMD_TX_CLEAR = 8'h20;
    localparam logic [7:0] CMD_RX_READ = 8'h91;
    localparam logic [7:0] CMD_RX_READ_NEXT = 8'h93;
    localparam logic [7:0] CMD_REG_LO_A = 8'h01;
    localparam logic [7:0] CMD_REG_HI_A = 8'h1B;
    localparam logic [7:0] CMD_REG_LO_B = 8'h95;
    localparam logic [7:0] CMD_REG_HI_B = 8'h9B;
    localparam logic [7:0] CMD_ADV_LO = 8'hB0;
    localparam logic [7:0] CMD_ADV_HI = 8'hBC;
    localparam logic [7:0] CMD_WR_LO = 8'hC0;
    localparam logic [7:0] CMD_WR_HI = 8'hCA;
    localparam int RX_DEPTH = 62;
    localparam logic [5:0] RX_FETCH_RST = 6'h00;
    localparam logic [5:0] RX_STORE_RST = 6'h01;
    localparam logic [5:0] RX_MSG_RST = 6'h00;
    localparam logic [5:0] RX_LAST_IDX = 6'h3D;
    localparam logic [7:0] RX_EMPTY_BYTE = 8'h00;
    localparam logic [2:0] TX_LAST_LOC = 3'h6;
    localparam logic [2:0] TX_PAST_LOC = 3'h7;
    localparam logic [7:0] TX_DEFAULT_BYTE = 8'h00;
    localparam logic [1:0] SLOT_RST = 2'h0;
    localparam int FIFO_DEPTH = 16;

    typedef struct packed {
        logic last;
        logic [7:0] data;
    } sbcd_rx_word_t;

    typedef enum logic [2:0] {
        SBCD_CMD, SBCD_REG_RD, SBCD_REG_WR, SBCD_RX_RD, SBCD_TX_WR, SBCD_IGNORE
    } sbcd_mode_t;
endpackage : sbcd_pkg

// ### sbcd_top.sv
module sbcd_fifo #(
    parameter int W = 9,
    parameter int D = 16
) (
    input wire logic clk_sys, // core clock
    input wire logic nrst, // async reset, active low
    input wire logic [W-1:0] in_data, // write word
    input wire logic in_valid, // write request
    output logic in_ready, // room for a word
    output logic [W-1:0] out_data, // head word
    output logic out_valid, // head word present
    input wire logic out_ready // head word taken
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_reg [D];
    logic [AW-1:0] wp_reg, rp_reg;
    logic [AW:0] cnt_reg, cnt_next;
    logic in_fire, out_fire;

    if (D < 2) begin : g_chk
        $error("fifo depth below 2");
    end

    assign in_fire = in_valid && in_ready;
    assign out_fire = out_valid && out_ready;
    assign out_data = mem_reg[rp_reg];
    assign out_valid = cnt_reg != '0;
    assign cnt_next = cnt_reg + (AW+1)'(in_fire) - (AW+1)'(out_fire);

    always_ff @(posedge clk_sys) begin
        if (in_fire) begin
            mem_reg[wp_reg] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
            in_ready <= 1'b1;
        end else begin
            if (in_fire) begin
                wp_reg <= (wp_reg == AW'(D-1)) ? '0 : wp_reg + AW'(1);
            end
            if (out_fire) begin
                rp_reg <= (rp_reg == AW'(D-1)) ? '0 : rp_reg + AW'(1);
            end
            cnt_reg <= cnt_next;
            in_ready <= cnt_next != (AW+1)'(D);
        end
    end
endmodule : sbcd_fifo

module sbcd_top (
    input wire logic clk_sys, // core clock
    input wire logic nrst, // async reset, active low
    input wire logic spi_sclk, // spi clock pin, mode 0
    input wire logic spi_cs_n, // spi select pin
    input wire logic spi_mosi, // spi data in
    output logic spi_miso, // spi data out
    output logic spi_miso_oe_n, // low while driving miso
    input wire sbcd_pkg::sbcd_rx_word_t rx_in, // received byte from uart
    input wire logic rx_in_valid, // received byte present
    output logic rx_in_ready, // fifo room
    input wire logic tx_done_stb, // uart finished sending a queue
    input wire logic [2:0] tx_rd_loc, // uart fetch location
    output logic [7:0] tx_rd_data, // byte of the send queue
    output logic [7:0] reg_addr, // register command byte
    output logic [7:0] reg_wr_data, // register write byte
    output logic reg_wr_stb, // register write pulse
    input wire logic [7:0] reg_rd_data, // register read byte
    output logic reg_rd_stb, // register byte fetched
    output logic [1:0] fill_slot_index, // load queue index
    output logic [1:0] send_slot_index, // send queue index
    output logic tx_overrun_flag, // advance refused on full
    output logic rx_overrun_flag, // receive overwrite happened
    output logic [5:0] rx_fetch_ptr, // receive read pointer
    output logic [5:0] rx_store_ptr, // receive write pointer
    output logic [5:0] rx_msg_start_ptr // oldest unread message
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    logic [2:0] pin_s1_reg, pin_s2_reg;
    logic sclk_d_reg, cs_d_reg;
    logic [2:0] bit_cnt_reg;
    logic [6:0] in_sh_reg;
    logic [7:0] out_sh_reg;
    logic load_req_reg, msg_done_reg, last_filled_reg;
    logic [2:0] tx_loc_reg;
    sbcd_pkg::sbcd_mode_t mode_reg;
    sbcd_pkg::sbcd_rx_word_t rx_mem_reg [sbcd_pkg::RX_DEPTH];
    logic [7:0] txq_reg [4][7];
    sbcd_pkg::sbcd_rx_word_t fifo_word;
    logic fifo_valid, fifo_ready, store_fire;
    logic sclk_s, cs_n_s, mosi_s, rise, fall, byte_done, cmd_done, data_done;
    logic [7:0] byte_in, peek;
    logic [5:0] fetch_inc, store_inc;
    logic rx_empty, tx_full, tx_empty, consume;
    logic cmd_clear, cmd_adv, cmd_adv_ok, cmd_wr, cmd_rd, cmd_rd_next, cmd_reg;

    function automatic logic [5:0] rx_inc(input logic [5:0] p);
        return (p == sbcd_pkg::RX_LAST_IDX) ? 6'h00 : p + 6'h01;
    endfunction : rx_inc

    sbcd_fifo #(.W($bits(sbcd_pkg::sbcd_rx_word_t)), .D(sbcd_pkg::FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .in_data(rx_in),
        .in_valid(rx_in_valid),
        .in_ready(rx_in_ready),
        .out_data(fifo_word),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready)
    );

    // pin synchronisers, stage two is the first one logic reads
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pin_s1_reg <= 3'h1;
            pin_s2_reg <= 3'h1;
            sclk_d_reg <= 1'b0;
            cs_d_reg <= 1'b1;
        end else begin
            pin_s1_reg <= {spi_mosi, spi_sclk, spi_cs_n};
            pin_s2_reg <= pin_s1_reg;
            sclk_d_reg <= sclk_s;
            cs_d_reg <= cs_n_s;
        end
    end

    assign cs_n_s = pin_s2_reg[0];
    assign sclk_s = pin_s2_reg[1];
    assign mosi_s = pin_s2_reg[2];
    assign rise = sclk_s && !sclk_d_reg && !cs_n_s;
    assign fall = !sclk_s && sclk_d_reg && !cs_n_s;
    assign byte_done = rise && (bit_cnt_reg == 3'h7);
    assign byte_in = {in_sh_reg, mosi_s};
    assign cmd_done = byte_done && (mode_reg == sbcd_pkg::SBCD_CMD);
    assign data_done = byte_done && (mode_reg != sbcd_pkg::SBCD_CMD);

    assign cmd_clear = cmd_done && (byte_in == sbcd_pkg::CMD_TX_CLEAR);
    assign cmd_rd = cmd_done && (byte_in == sbcd_pkg::CMD_RX_READ);
    assign cmd_rd_next = cmd_done && (byte_in == sbcd_pkg::CMD_RX_READ_NEXT);
    assign cmd_adv = cmd_done && !byte_in[0] && (byte_in >= sbcd_pkg::CMD_ADV_LO)
        && (byte_in <= sbcd_pkg::CMD_ADV_HI);
    assign cmd_wr = cmd_done && !byte_in[0] && (byte_in >= sbcd_pkg::CMD_WR_LO)
        && (byte_in <= sbcd_pkg::CMD_WR_HI);
    assign cmd_reg = cmd_done && (((byte_in >= sbcd_pkg::CMD_REG_LO_A)
        && (byte_in <= sbcd_pkg::CMD_REG_HI_A)) || ((byte_in >= sbcd_pkg::CMD_REG_LO_B)
        && (byte_in <= sbcd_pkg::CMD_REG_HI_B))); // RQ6

    assign fetch_inc = rx_inc(rx_fetch_ptr);
    assign store_inc = rx_inc(rx_store_ptr);
    assign rx_empty = (fetch_inc == rx_store_ptr); // RQ17
    assign peek = (rx_empty || msg_done_reg) ? sbcd_pkg::RX_EMPTY_BYTE
        : rx_mem_reg[fetch_inc].data; // RQ17
    assign consume = data_done && (mode_reg == sbcd_pkg::SBCD_RX_RD) && !rx_empty
        && !msg_done_reg;
    assign fifo_ready = !consume;
    assign store_fire = fifo_valid && fifo_ready;
    assign tx_empty = (fill_slot_index == send_slot_index);
    assign tx_full = ((fill_slot_index + 2'h1) == send_slot_index);
    assign cmd_adv_ok = cmd_adv && !tx_full;

    // serial framing and command decode
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bit_cnt_reg <= 3'h0;
            in_sh_reg <= 7'h00;
            mode_reg <= sbcd_pkg::SBCD_CMD;
            reg_addr <= 8'h00;
        end else if (cs_n_s) begin
            bit_cnt_reg <= 3'h0;
            mode_reg <= sbcd_pkg::SBCD_CMD;
        end else if (rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            in_sh_reg <= byte_in[6:0];
            if (cmd_done) begin
                reg_addr <= byte_in;
                if (cmd_reg) begin
                    mode_reg <= byte_in[0] ? sbcd_pkg::SBCD_REG_RD : sbcd_pkg::SBCD_REG_WR;
                end else if (cmd_rd || cmd_rd_next) begin
                    mode_reg <= sbcd_pkg::SBCD_RX_RD;
                end else if (cmd_adv || cmd_wr) begin
                    mode_reg <= sbcd_pkg::SBCD_TX_WR;
                end else begin
                    mode_reg <= sbcd_pkg::SBCD_IGNORE; // RQ18
                end
            end
        end
    end

    // miso shifter, next byte loaded one cycle after a byte ends
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            load_req_reg <= 1'b0;
            out_sh_reg <= 8'h00;
            spi_miso <= 1'b0;
            spi_miso_oe_n <= 1'b1;
            reg_rd_stb <= 1'b0;
        end else begin
            load_req_reg <= byte_done;
            reg_rd_stb <= 1'b0;
            if (cs_n_s && !cs_d_reg) begin
                out_sh_reg <= 8'h00;
            end else if (load_req_reg) begin
                unique case (mode_reg)
                    sbcd_pkg::SBCD_RX_RD: out_sh_reg <= peek;
                    sbcd_pkg::SBCD_REG_RD: begin
                        out_sh_reg <= reg_rd_data;
                        reg_rd_stb <= 1'b1;
                    end
                    sbcd_pkg::SBCD_CMD, sbcd_pkg::SBCD_REG_WR, sbcd_pkg::SBCD_TX_WR,
                    sbcd_pkg::SBCD_IGNORE: out_sh_reg <= 8'h00;
                endcase
            end else if (fall && (bit_cnt_reg != 3'h0)) begin
                out_sh_reg <= {out_sh_reg[6:0], 1'b0};
            end
            spi_miso <= out_sh_reg[7];
            spi_miso_oe_n <= cs_n_s;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reg_wr_data <= 8'h00;
            reg_wr_stb <= 1'b0;
        end else begin
            reg_wr_stb <= data_done && (mode_reg == sbcd_pkg::SBCD_REG_WR); // RQ6
            if (data_done) begin
                reg_wr_data <= byte_in;
            end
        end
    end

    // receive fetch side
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rx_fetch_ptr <= sbcd_pkg::RX_FETCH_RST;
            rx_msg_start_ptr <= sbcd_pkg::RX_MSG_RST;
            msg_done_reg <= 1'b0;
        end else if (cmd_done) begin
            msg_done_reg <= 1'b0;
            if (cmd_rd_next) begin
                rx_fetch_ptr <= rx_msg_start_ptr; // RQ9
            end
        end else if (consume) begin
            rx_fetch_ptr <= fetch_inc; // RQ8
            if (rx_mem_reg[fetch_inc].last) begin
                msg_done_reg <= 1'b1; // RQ8 RQ9
                rx_msg_start_ptr <= fetch_inc;
            end
        end
    end

    // receive store side and overflow policy
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rx_store_ptr <= sbcd_pkg::RX_STORE_RST;
            last_filled_reg <= 1'b0;
            rx_overrun_flag <= 1'b0;
        end else begin
            if (store_fire) begin
                if (store_inc != rx_fetch_ptr) begin
                    rx_store_ptr <= store_inc; // RQ2
                end else begin
                    last_filled_reg <= 1'b1;
                end
                if (last_filled_reg) begin
                    rx_overrun_flag <= 1'b1; // RQ3
                end
            end else if (consume) begin
                rx_overrun_flag <= 1'b0; // RQ4
                if (last_filled_reg) begin
                    rx_store_ptr <= store_inc;
                    last_filled_reg <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < sbcd_pkg::RX_DEPTH; i++) begin
                rx_mem_reg[i] <= '0;
            end
        end else if (store_fire) begin
            rx_mem_reg[rx_store_ptr] <= fifo_word; // RQ3
        end else if (consume) begin
            rx_mem_reg[fetch_inc] <= '0;
        end
    end

    // transmit slot indexes
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fill_slot_index <= sbcd_pkg::SLOT_RST;
            send_slot_index <= sbcd_pkg::SLOT_RST;
            tx_overrun_flag <= 1'b0;
        end else if (cmd_clear) begin
            fill_slot_index <= sbcd_pkg::SLOT_RST; // RQ7
            send_slot_index <= sbcd_pkg::SLOT_RST;
            tx_overrun_flag <= 1'b0;
        end else begin
            if (cmd_adv_ok) begin
                fill_slot_index <= fill_slot_index + 2'h1; // RQ10 RQ11 RQ15
            end else if (cmd_adv) begin
                tx_overrun_flag <= 1'b1; // RQ16
            end
            if (tx_done_stb && !tx_empty) begin
                send_slot_index <= send_slot_index + 2'h1; // RQ15
            end
        end
    end

    // load queue storage
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tx_loc_reg <= 3'h0;
            tx_rd_data <= 8'h00;
            for (int q = 0; q < 4; q++) begin
                for (int l = 0; l < 7; l++) begin
                    txq_reg[q][l] <= sbcd_pkg::TX_DEFAULT_BYTE;
                end
            end
        end else begin
            tx_rd_data <= (tx_rd_loc > sbcd_pkg::TX_LAST_LOC) ? 8'h00
                : txq_reg[send_slot_index][tx_rd_loc];
            if (cmd_clear) begin
                for (int q = 0; q < 4; q++) begin
                    for (int l = 0; l < 7; l++) begin
                        txq_reg[q][l] <= sbcd_pkg::TX_DEFAULT_BYTE; // RQ7
                    end
                end
            end else begin
                if (tx_done_stb && !tx_empty) begin
                    for (int l = 0; l < 7; l++) begin
                        txq_reg[send_slot_index][l] <= sbcd_pkg::TX_DEFAULT_BYTE;
                    end
                end
                if (cmd_adv || cmd_wr) begin
                    tx_loc_reg <= byte_in[3:1]; // RQ12 RQ14
                end else if (data_done && (mode_reg == sbcd_pkg::SBCD_TX_WR)
                        && (tx_loc_reg <= sbcd_pkg::TX_LAST_LOC)) begin // RQ13
                    txq_reg[fill_slot_index][tx_loc_reg] <= byte_in; // RQ10 RQ12
                    tx_loc_reg <= tx_loc_reg + 3'h1;
                end
            end
        end
    end

    sequence s_last_consumed;
        consume && rx_mem_reg[fetch_inc].last;
    endsequence
    property p_store_off_fetch;
        rx_store_ptr != rx_fetch_ptr;
    endproperty
    a_store_off_fetch: assert property (p_store_off_fetch) else $error("store on fetch"); // RQ2
    property p_overrun_set;
        store_fire && last_filled_reg |=> rx_overrun_flag && $stable(rx_store_ptr);
    endproperty
    a_overrun_set: assert property (p_overrun_set) else $error("overrun not flagged"); // RQ3
    property p_overrun_clear;
        consume && !store_fire |=> !rx_overrun_flag;
    endproperty
    a_overrun_clear: assert property (p_overrun_clear) else $error("overrun kept"); // RQ4
    property p_tx_clear;
        cmd_clear |=> fill_slot_index == 2'h0 && send_slot_index == 2'h0 && !tx_overrun_flag;
    endproperty
    a_tx_clear: assert property (p_tx_clear) else $error("clear failed"); // RQ7
    property p_msg_stop;
        s_last_consumed |=> msg_done_reg ##0 (!consume)[*1] ##0 1'b1;
    endproperty
    a_msg_stop: assert property (p_msg_stop) else $error("read past message"); // RQ8
    property p_adv;
        cmd_adv_ok |=> fill_slot_index == $past(fill_slot_index) + 2'h1;
    endproperty
    a_adv: assert property (p_adv) else $error("advance missing"); // RQ11
    property p_adv_full;
        cmd_adv && tx_full |=> $stable(fill_slot_index) && tx_overrun_flag;
    endproperty
    a_adv_full: assert property (p_adv_full) else $error("full advance"); // RQ16
    property p_empty_read;
        data_done && mode_reg == sbcd_pkg::SBCD_RX_RD && rx_empty |=> $stable(rx_fetch_ptr);
    endproperty
    a_empty_read: assert property (p_empty_read) else $error("empty read moved"); // RQ17
    property p_ignore;
        data_done && mode_reg == sbcd_pkg::SBCD_IGNORE && !tx_done_stb
            |=> $stable(fill_slot_index) && $stable(rx_fetch_ptr);
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignored cmd acted"); // RQ18
endmodule : sbcd_top

// ### sbcd_host_model.sv
module sbcd_host_model (
    input wire logic clk_sys, // core clock
    output logic spi_sclk, // spi clock, idle low
    output logic spi_cs_n, // select, active low
    output logic spi_mosi, // data to device
    input wire logic spi_miso, // data from device
    input wire logic spi_miso_oe_n // low while device drives
);
    timeunit 1ns;
    timeprecision 1ns;
    int half_clk = 5;
    int n_oe_bad = 0;
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : idle
    task automatic begin_frame();
        idle(1);
        spi_cs_n = 1'b0;
        idle(half_clk);
    endtask : begin_frame
    // mode 0: mosi moves with the falling edge, miso taken at the rise
    task automatic xfer(input logic [7:0] tx_byte, output logic [7:0] rx_byte);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi = tx_byte[i];
            idle(half_clk);
            if (spi_miso_oe_n !== 1'b0) n_oe_bad++;
            rx_byte[i] = spi_miso;
            spi_sclk = 1'b1;
            idle(half_clk);
            spi_sclk = 1'b0;
        end
    endtask : xfer
    task automatic end_frame();
        idle(half_clk);
        spi_cs_n = 1'b1;
        // released line must not keep the last bit
        spi_mosi = ~spi_mosi;
        idle(8);
    endtask : end_frame
endmodule : sbcd_host_model

// ### spi_buffer_command_decoder_test.sv
module spi_buffer_command_decoder_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, nrst, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
    sbcd_pkg::sbcd_rx_word_t rx_in;
    logic rx_in_valid, rx_in_ready, tx_done_stb, reg_wr_stb, reg_rd_stb;
    logic tx_overrun_flag, rx_overrun_flag;
    logic [2:0] tx_rd_loc;
    logic [7:0] tx_rd_data, reg_addr, reg_wr_data, reg_rd_data;
    logic [1:0] fill_slot_index, send_slot_index;
    logic [5:0] rx_fetch_ptr, rx_store_ptr, rx_msg_start_ptr;
    int n_mismatch = 0;
    int samples_checked = 0;
    int n_wr = 0;
    int n_rd = 0;
    logic [7:0] txb [8];
    logic [7:0] rxb [8];

    sbcd_top dut (.clk_sys(clk_sys), .nrst(nrst), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe_n(spi_miso_oe_n), .rx_in(rx_in), .rx_in_valid(rx_in_valid),
        .rx_in_ready(rx_in_ready), .tx_done_stb(tx_done_stb), .tx_rd_loc(tx_rd_loc),
        .tx_rd_data(tx_rd_data), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
        .reg_wr_stb(reg_wr_stb), .reg_rd_data(reg_rd_data), .reg_rd_stb(reg_rd_stb),
        .fill_slot_index(fill_slot_index), .send_slot_index(send_slot_index),
        .tx_overrun_flag(tx_overrun_flag), .rx_overrun_flag(rx_overrun_flag),
        .rx_fetch_ptr(rx_fetch_ptr), .rx_store_ptr(rx_store_ptr),
        .rx_msg_start_ptr(rx_msg_start_ptr));
    sbcd_host_model host (.clk_sys(clk_sys), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (reg_wr_stb === 1'b1) n_wr++;
        if (reg_rd_stb === 1'b1) n_rd++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    task automatic frame(input logic [7:0] cmd, input int n);
        logic [7:0] dummy;
        host.begin_frame();
        host.xfer(cmd, dummy);
        for (int i = 0; i < n; i++) host.xfer(txb[i], rxb[i]);
        host.end_frame();
    endtask : frame
    task automatic push(input logic last, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk_sys);
        rx_in = {last, d};
        rx_in_valid = 1'b1;
        while (rx_in_ready !== 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 100) chk(rx_in_ready, 1'b1);
        @(posedge clk_sys);
    endtask : push
    task automatic stop_rx();
        host.idle(1);
        rx_in_valid = 1'b0;
        host.idle(6);
    endtask : stop_rx
    task automatic qchk(input logic [2:0] loc, input logic [7:0] exp);
        @(negedge clk_sys);
        tx_rd_loc = loc;
        host.idle(2);
        chk(tx_rd_data, exp);
    endtask : qchk
    task automatic done_pulse();
        @(negedge clk_sys);
        tx_done_stb = 1'b1;
        @(negedge clk_sys);
        tx_done_stb = 1'b0;
    endtask : done_pulse

    task automatic t_reset_values();
        chk(rx_fetch_ptr, 6'h00);
        chk(rx_store_ptr, 6'h01);
        chk(rx_msg_start_ptr, 6'h00);
        chk(spi_miso_oe_n, 1'b1);
        chk(rx_in_ready, 1'b1);
    endtask : t_reset_values
    task automatic t_regs();
        logic [7:0] codes [4] = '{8'h01, 8'h1B, 8'h95, 8'h9B};
        for (int i = 0; i < 4; i++) begin
            frame(codes[i], 1);
            chk(reg_addr, codes[i]);
            chk(rxb[0], 8'hA5);
        end
        chk(n_rd, 8);
        n_wr = 0;
        txb[0] = 8'h3C;
        frame(8'h10, 1);
        chk(reg_wr_data, 8'h3C);
        chk(n_wr, 1);
    endtask : t_regs
    task automatic t_tx_queue();
        frame(8'hB0, 0);
        chk(fill_slot_index, 2'h1);
        txb[0] = 8'h5A;
        txb[1] = 8'h6B;
        txb[2] = 8'h7C;
        txb[3] = 8'h8D;
        frame(8'hBA, 4);
        chk(fill_slot_index, 2'h2);
        txb[0] = 8'h11;
        frame(8'hC2, 1);
        chk(fill_slot_index, 2'h2);
        txb[0] = 8'h55;
        frame(8'h40, 2);
        chk(fill_slot_index, 2'h2);
        frame(8'hB1, 0);
        chk(fill_slot_index, 2'h2);
        done_pulse();
        done_pulse();
        chk(send_slot_index, 2'h2);
        qchk(3'h0, 8'h00);
        qchk(3'h1, 8'h11);
        qchk(3'h2, 8'h00);
        qchk(3'h5, 8'h5A);
        qchk(3'h6, 8'h6B);
    endtask : t_tx_queue
    task automatic t_tx_full();
        for (int i = 0; i < 3; i++) frame(8'hB0, 0);
        chk(fill_slot_index, 2'h1);
        chk(tx_overrun_flag, 1'b0);
        frame(8'hB0, 0);
        chk(fill_slot_index, 2'h1);
        chk(tx_overrun_flag, 1'b1);
        frame(8'h20, 0);
        chk({fill_slot_index, send_slot_index}, 4'h0);
        chk(tx_overrun_flag, 1'b0);
    endtask : t_tx_full
    task automatic t_rx_read();
        push(1'b0, 8'hA1);
        push(1'b0, 8'hA2);
        push(1'b1, 8'hA3);
        push(1'b0, 8'hB1);
        push(1'b1, 8'hB2);
        stop_rx();
        chk(rx_store_ptr, 6'h06);
        frame(8'h91, 5);
        chk({rxb[0], rxb[1], rxb[2]}, 24'hA1A2A3);
        chk({rxb[3], rxb[4]}, 16'h0000);
        chk(rx_fetch_ptr, 6'h03);
        chk(rx_msg_start_ptr, 6'h03);
        frame(8'h93, 3);
        chk({rxb[0], rxb[1], rxb[2]}, 24'hB1B200);
        chk(rx_fetch_ptr, 6'h05);
        frame(8'h91, 1);
        chk(rxb[0], 8'h00);
        chk(rx_fetch_ptr, 6'h05);
    endtask : t_rx_read
    task automatic t_rx_overrun();
        logic [7:0] v;
        v = 8'h80;
        for (int i = 0; i < 61; i++) begin
            push(1'b0, v);
            v++;
        end
        stop_rx();
        chk(rx_store_ptr, 6'h04);
        chk(rx_overrun_flag, 1'b0);
        push(1'b0, v);
        stop_rx();
        chk(rx_store_ptr, 6'h04);
        chk(rx_overrun_flag, 1'b1);
        frame(8'h91, 2);
        chk({rxb[0], rxb[1]}, 16'h8081);
        chk(rx_overrun_flag, 1'b0);
        chk(host.n_oe_bad, 0);
    endtask : t_rx_overrun

    initial begin
        nrst = 1'b0;
        rx_in = '0;
        rx_in_valid = 1'b0;
        tx_done_stb = 1'b0;
        tx_rd_loc = 3'h0;
        reg_rd_data = 8'hA5;
        repeat (16) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (4) @(negedge clk_sys);
        t_reset_values();
        t_regs();
        t_tx_queue();
        t_tx_full();
        t_rx_read();
        t_rx_overrun();
        give_verdict();
    end
    initial begin
        repeat (40000) @(posedge clk_sys);
        n_mismatch++;
        give_verdict();
    end
endmodule : spi_buffer_command_decoder_test
